// [trip_pkg.sv]
// Constants and types for the trip latch supervisor
//------------------------------------------------------------
// What this block does
//------------------------------------------------------------
// What this block does
// RULE1: Any detected trip disables the power stage at once so the motor coasts without braking.
// RULE2: Each trip is held in a latch until a reset action, even after its source goes away.
// RULE3: While any trip is latched the fault-free indicator is off on the unit and on the keypad.
// RULE4: While any trip is latched the fault-free output terminal is driven low.
// RULE5: The keypad shows the alarm and the acknowledge key clears only the message, never restarting the drive.
// RULE6: The power stage is never re-enabled while any latched trip remains.
// RULE7: A reset clears a trip latch only if that trip's source is no longer present.
// RULE8: Several trips may be latched at once, including ones that appear after the drive has stopped.
// RULE9: Power-up or a cycle of the auxiliary supply clears every latched trip whose source is inactive.
// RULE10: Withdrawing and reasserting start/run, from terminals or keys, is a reset request.
// RULE11: After a successful reset the indicator relights and the keypad returns to its previous display.
// RULE12: In configuration mode running is inhibited and outputs are frozen, while value changes are still taken.
// RULE13: In operating mode link changes are refused, value changes accepted, and stop-only changes refused while running.
// RULE14: The tripped state is the OR of all trip latches and drives the disable and indicators together; the code also ORs in the live trip sources.
package trip_pkg;

    localparam int NUM_TRIPS = 16;
    localparam int OVERVOLT_BIT = 5;
    localparam logic [15:0] LATCH_RESET = 16'h0000;

    typedef enum logic [1:0] {
        DISP_NORMAL,
        DISP_ALARM,
        DISP_ACKED
    } disp_e;

endpackage : trip_pkg

// [trip_if.sv]
// Interface carrying run-command events between the supervisor and its edge detector
interface trip_if;
    logic cmd_level;
    logic cmd_drop;
    logic cmd_rise;

    modport src (input cmd_level, output cmd_drop, output cmd_rise);
    modport dst (output cmd_level, input cmd_drop, input cmd_rise);
endinterface : trip_if

// [run_edge.sv]
// Edge detector for the combined start/run command
module run_edge
(
    input wire logic clk,
    input wire logic rst_b,
    trip_if.src ev
);
    logic prev_ff;
    logic nxt_prev;

    always_comb
    begin
        nxt_prev = ev.cmd_level;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            prev_ff <= 1'h0;
        else
            prev_ff <= nxt_prev;
    end

    // A rising command after a withdrawal is the reset request
    assign ev.cmd_drop = prev_ff & ~ev.cmd_level;
    assign ev.cmd_rise = ~prev_ff & ev.cmd_level; // [RULE10]

endmodule : run_edge

// [trip_latch_supervisor.sv]
// Trip latch supervisor: latches trips, gates the power stage and drives indicators
module trip_latch_supervisor
    import trip_pkg::*;
#(
    parameter int N = NUM_TRIPS
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [N-1:0] trip_src,
    input wire logic start_input,
    input wire logic run_input,
    input wire logic key_run,
    input wire logic key_stop,
    input wire logic key_ack,
    input wire logic aux_supply_ok,
    input wire logic config_mode,
    input wire logic link_change_req,
    input wire logic value_change_req,
    input wire logic stop_only_req,
    input wire logic run_demand,
    input wire logic [7:0] out_value,
    output logic power_enable,
    output logic fault_free_indicator,
    output logic fault_free_output,
    output logic [N-1:0] trip_latched,
    output logic [1:0] operator_keypad,
    output logic change_accept,
    output logic change_reject,
    output logic [7:0] out_hold
);

    //------------------------------------------------------------
    // Run command events
    //------------------------------------------------------------
    trip_if ev ();
    logic key_cmd_ff;
    logic nxt_key_cmd;
    logic aux_prev_ff;
    logic nxt_aux_prev;

    // Keys act as a latched run command so they can share the terminal path
    always_comb
    begin
        nxt_key_cmd = key_cmd_ff;
        // Stop wins so a held run key cannot mask a stop
        if (key_stop)
            nxt_key_cmd = 1'h0;
        else if (key_run)
            nxt_key_cmd = 1'h1;
        nxt_aux_prev = aux_supply_ok;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            key_cmd_ff <= 1'h0;
            // Starts high so leaving reset is not taken for an aux return
            aux_prev_ff <= 1'h1;
        end
        else
        begin
            key_cmd_ff <= nxt_key_cmd;
            aux_prev_ff <= nxt_aux_prev;
        end
    end

    // Either terminal or the key command withdrawn counts as a stop
    assign ev.cmd_level = start_input & run_input & key_cmd_ff;

    run_edge u_edge (
        .clk(clk),
        .rst_b(rst_b),
        .ev(ev)
    );

    logic aux_return;
    logic reset_req;
    assign aux_return = aux_supply_ok & ~aux_prev_ff; // [RULE9]
    assign reset_req = ev.cmd_rise | aux_return; // [RULE10]

    //------------------------------------------------------------
    // Trip latches
    //------------------------------------------------------------
    logic [N-1:0] latch_ff;
    logic [N-1:0] nxt_latch;

    // One latch per source; a live source wins over any reset request
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_latch
            always_comb
            begin
                nxt_latch[g] = latch_ff[g];
                if (trip_src[g])
                    nxt_latch[g] = 1'h1; // [RULE2] [RULE8]
                else if (reset_req)
                    nxt_latch[g] = 1'h0; // [RULE7]
            end

            // Per-bit checks, clocked here as default clocking sits further down
            latch_set_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
                trip_src[g] |=> latch_ff[g])
                else $error("trip latch not set");
            latch_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
                latch_ff[g] && reset_req && !trip_src[g] |=> !latch_ff[g])
                else $error("trip latch not cleared");
        end
    endgenerate

    // Power-up reset starts clear; sources still active relatch next edge
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            latch_ff <= N'(LATCH_RESET); // [RULE9]
        else
            latch_ff <= nxt_latch;
    end

    // Include live sources so disable does not wait a cycle for the latch
    logic tripped;
    assign tripped = (|latch_ff) | (|trip_src); // [RULE14]

    //------------------------------------------------------------
    // Keypad display
    //------------------------------------------------------------
    disp_e disp_ff;
    disp_e nxt_disp;

    // Keypad stays off its normal display until the trip has cleared, acknowledged or not
    always_comb
    begin
        nxt_disp = disp_ff;
        case (disp_ff)
            DISP_NORMAL:
                if (tripped)
                    nxt_disp = DISP_ALARM;
            DISP_ALARM:
                if (!tripped)
                    nxt_disp = DISP_NORMAL; // [RULE11]
                else if (key_ack)
                    nxt_disp = DISP_ACKED; // [RULE5]
            DISP_ACKED:
                if (!tripped)
                    nxt_disp = DISP_NORMAL; // [RULE11]
            default:
                nxt_disp = DISP_NORMAL;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            disp_ff <= DISP_NORMAL;
        else
            disp_ff <= nxt_disp;
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    logic pwr_ff;
    logic ind_ff;
    logic ffo_ff;
    logic acc_ff;
    logic rej_ff;
    logic [7:0] hold_ff;
    logic nxt_pwr;
    logic nxt_ind;
    logic nxt_ffo;
    logic nxt_acc;
    logic nxt_rej;
    logic [7:0] nxt_hold;
    logic running;

    always_comb
    begin
        // Ack never appears here, so it cannot restart the drive
        nxt_pwr = run_demand & ev.cmd_level & ~tripped & ~config_mode; // [RULE1] [RULE6] [RULE12]
        nxt_ind = ~tripped; // [RULE3] [RULE11]
        nxt_ffo = ~tripped; // [RULE4]
        // Frozen value keeps the outputs still while links are edited
        nxt_hold = config_mode ? hold_ff : out_value; // [RULE12]
        nxt_acc = 1'h0;
        nxt_rej = 1'h0;
        // Link outranks stop-only, which outranks a plain value change
        if (link_change_req)
        begin
            nxt_acc = config_mode;
            nxt_rej = ~config_mode; // [RULE13]
        end
        else if (stop_only_req)
        begin
            nxt_acc = ~running;
            nxt_rej = running; // [RULE13]
        end
        else if (value_change_req)
            nxt_acc = 1'h1; // [RULE12] [RULE13]
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pwr_ff <= 1'h0;
            ind_ff <= 1'h0;
            ffo_ff <= 1'h0;
            acc_ff <= 1'h0;
            rej_ff <= 1'h0;
            hold_ff <= 8'h00;
        end
        else
        begin
            pwr_ff <= nxt_pwr;
            ind_ff <= nxt_ind;
            ffo_ff <= nxt_ffo;
            acc_ff <= nxt_acc;
            rej_ff <= nxt_rej;
            hold_ff <= nxt_hold;
        end
    end

    assign running = pwr_ff;
    assign power_enable = pwr_ff;
    assign fault_free_indicator = ind_ff;
    assign fault_free_output = ffo_ff;
    assign trip_latched = latch_ff;
    assign operator_keypad = disp_ff;
    assign change_accept = acc_ff;
    assign change_reject = rej_ff;
    assign out_hold = hold_ff;

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    trip_kills_power_a: assert property (|trip_src |=> !power_enable) // [RULE1]
        else $error("power stage on after a trip");
    latch_holds_a: assert property (latch_ff[0] && !reset_req |=> latch_ff[0]) // [RULE2]
        else $error("trip latch lost without reset");
    lamp_off_a: assert property (|latch_ff |=> !fault_free_indicator) // [RULE3]
        else $error("indicator lit while tripped");
    output_low_a: assert property (|latch_ff |=> !fault_free_output) // [RULE4]
        else $error("fault-free output high while tripped");
    ack_no_run_a: assert property (key_ack && |latch_ff |=> !power_enable) // [RULE5]
        else $error("acknowledge re-enabled drive");
    no_reenable_a: assert property (power_enable |-> $past(latch_ff) == '0) // [RULE6]
        else $error("enabled with latched trip");
    live_src_stays_a: assert property (trip_src[0] |=> latch_ff[0]) // [RULE7]
        else $error("active source latch cleared");
    multi_latch_a: assert property (&trip_src[1:0] |=> &latch_ff[1:0]) // [RULE8]
        else $error("simultaneous trips not both latched");
    aux_clear_a: assert property (aux_return && !trip_src[0] |=> !latch_ff[0]) // [RULE9]
        else $error("aux cycle did not clear latch");
    cycle_clear_a: assert property (ev.cmd_rise && !trip_src[0] |=> !latch_ff[0]) // [RULE10]
        else $error("run cycle did not clear latch");
    relight_a: assert property ($fell(|latch_ff) && !(|trip_src) |=> fault_free_indicator) // [RULE11]
        else $error("indicator not relit");
    config_hold_a: assert property (config_mode |=> !power_enable && out_hold == $past(out_hold)) // [RULE12]
        else $error("ran or updated in configuration mode");
    link_reject_a: assert property (link_change_req && !config_mode |=> change_reject) // [RULE13]
        else $error("link change taken in operating mode");

    // Display, change requests and run command
    alarm_shown_a: assert property (tripped && disp_ff == DISP_NORMAL |=> disp_ff == DISP_ALARM) // [RULE5]
        else $error("alarm not shown on trip");
    ack_marks_a: assert property (key_ack && tripped && disp_ff == DISP_ALARM |=> disp_ff == DISP_ACKED) // [RULE5]
        else $error("acknowledge not taken");
    acked_holds_a: assert property (tripped && disp_ff == DISP_ACKED |=> disp_ff == DISP_ACKED) // [RULE5]
        else $error("acknowledged alarm lost while tripped");
    display_back_a: assert property (!tripped && disp_ff != DISP_NORMAL |=> disp_ff == DISP_NORMAL) // [RULE11]
        else $error("keypad did not return to its display");
    ind_follows_a: assert property (|trip_src |=> !fault_free_indicator && !fault_free_output) // [RULE3] [RULE4]
        else $error("indicators lit with a live trip");
    stop_only_a: assert property (stop_only_req && !link_change_req |=> change_reject == $past(running)) // [RULE13]
        else $error("stop-only change misjudged");
    value_ok_a: assert property (value_change_req && !link_change_req && !stop_only_req |=> change_accept) // [RULE13]
        else $error("value change refused");
    link_take_a: assert property (link_change_req && config_mode |=> change_accept) // [RULE12]
        else $error("link change refused in configuration mode");
    hold_follow_a: assert property (!config_mode |=> out_hold == $past(out_value)) // [RULE12]
        else $error("output value not passed in operating mode");
    run_needs_cmd_a: assert property (power_enable |-> $past(ev.cmd_level) && $past(run_demand)) // [RULE10]
        else $error("running without a run command");
    stop_key_halts_a: assert property (key_stop |-> ##2 !power_enable) // [RULE10]
        else $error("stop key did not stop the drive");
    terminal_halts_a: assert property (!start_input || !run_input |=> !power_enable) // [RULE10]
        else $error("withdrawn terminal did not stop the drive");

    //------------------------------------------------------------
    // Cover points
    //------------------------------------------------------------
    drop_seen_c: cover property (ev.cmd_drop);
    trip_seen_c: cover property (!fault_free_output ##[1:20] fault_free_output);
    ack_seen_c: cover property (operator_keypad == 2'(DISP_ACKED));
    multi_seen_c: cover property ($countones(latch_ff) > 1);
    run_seen_c: cover property (power_enable);

endmodule : trip_latch_supervisor

// [keypad_model.sv]
// Operator keypad and start/run terminal model
module keypad_model
(
    input wire logic clk,
    output logic start_input,
    output logic run_input,
    output logic key_run,
    output logic key_stop,
    output logic key_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    //------------------------------------------------------------
    // Levels at power-up
    //------------------------------------------------------------
    // Terminals held asserted; the key command still needs a run key
    initial
    begin
        start_input = 1'h1;
        run_input = 1'h1;
        key_run = 1'h0;
        key_stop = 1'h0;
        key_ack = 1'h0;
    end
    //------------------------------------------------------------
    // Operator actions
    //------------------------------------------------------------
    task term_cycle;
        @(posedge clk) start_input <= 1'h0;
        repeat (2) @(posedge clk);
        start_input <= 1'h1;
        @(posedge clk);
    endtask : term_cycle
    task run_cycle;
        @(posedge clk) run_input <= 1'h0;
        repeat (2) @(posedge clk);
        run_input <= 1'h1;
        @(posedge clk);
    endtask : run_cycle
    // Stop then run keys; a stop pulse alone never restarts
    task key_cycle;
        @(posedge clk) key_stop <= 1'h1;
        @(posedge clk) key_stop <= 1'h0;
        @(posedge clk) key_run <= 1'h1;
        @(posedge clk) key_run <= 1'h0;
    endtask : key_cycle
    task ack;
        @(posedge clk) key_ack <= 1'h1;
        @(posedge clk) key_ack <= 1'h0;
    endtask : ack
endmodule : keypad_model

// [testbench.sv]
// Self-checking bench for the trip latch supervisor
module testbench
    import trip_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [15:0] trip_src = 16'h0000;
    logic aux_supply_ok = 1'h1;
    logic config_mode = 1'h0;
    logic link_change_req = 1'h0;
    logic value_change_req = 1'h0;
    logic stop_only_req = 1'h0;
    logic run_demand = 1'h0;
    logic [7:0] out_value = 8'h00;
    wire logic start_input, run_input, key_run, key_stop, key_ack;
    logic power_enable, fault_free_indicator, fault_free_output, change_accept, change_reject;
    logic [15:0] trip_latched;
    logic [1:0] operator_keypad;
    logic [7:0] out_hold;
    int n_mismatch = 0;
    int checked = 0;
    //------------------------------------------------------------
    // Clock, partner and design
    //------------------------------------------------------------
    initial
    begin
        forever #50 clk = ~clk;
    end
    keypad_model kp (.clk(clk), .start_input(start_input), .run_input(run_input),
        .key_run(key_run), .key_stop(key_stop), .key_ack(key_ack));
    trip_latch_supervisor DUT (.clk(clk), .rst_b(rst_b), .trip_src(trip_src), .start_input(start_input),
        .run_input(run_input), .key_run(key_run), .key_stop(key_stop), .key_ack(key_ack),
        .aux_supply_ok(aux_supply_ok), .config_mode(config_mode), .link_change_req(link_change_req),
        .value_change_req(value_change_req), .stop_only_req(stop_only_req), .run_demand(run_demand),
        .out_value(out_value), .power_enable(power_enable), .fault_free_indicator(fault_free_indicator),
        .fault_free_output(fault_free_output), .trip_latched(trip_latched),
        .operator_keypad(operator_keypad), .change_accept(change_accept),
        .change_reject(change_reject), .out_hold(out_hold));
    //------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------
    task summarize;
        $display("mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    task chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Bounded wait; running may take a few edges to come back
    task wait_pe(input logic v);
        int i;
        i = 0;
        while (power_enable !== v && i < 20)
        begin
            tick(1);
            i++;
        end
        chk(power_enable, v);
        if (power_enable !== v)
            summarize();
    endtask : wait_pe
    // Request pulse, answered one edge later
    task req(input int k, input logic acc);
        @(posedge clk);
        link_change_req <= (k == 0);
        stop_only_req <= (k == 1);
        value_change_req <= (k == 2);
        @(posedge clk);
        {link_change_req, stop_only_req, value_change_req} <= 3'h0;
        #1;
        chk({change_accept, change_reject}, {acc, ~acc});
    endtask : req
    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    task s_power;
        run_demand <= 1'h1;
        kp.key_cycle();
        wait_pe(1'h1);
        chk({fault_free_indicator, fault_free_output}, 16'h3);
        chk(trip_latched, 16'h0000);
    endtask : s_power
    // Transient trip, late second trip, ack, partial then full reset
    task s_trip;
        @(posedge clk) trip_src <= 16'h0001 << OVERVOLT_BIT;
        @(posedge clk) trip_src <= 16'h0000;
        #1;
        chk(power_enable, 16'h0);
        chk({fault_free_indicator, fault_free_output}, 16'h0);
        tick(3);
        chk(trip_latched, 16'h0020);
        chk(operator_keypad, DISP_ALARM);
        trip_src <= 16'h0008;
        tick(2);
        chk(trip_latched, 16'h0028);
        kp.ack();
        tick(1);
        chk({operator_keypad, power_enable}, {DISP_ACKED, 1'h0});
        kp.term_cycle();
        tick(3);
        chk({trip_latched, power_enable}, {16'h0008, 1'h0});
        trip_src <= 16'h0000;
        kp.key_cycle();
        tick(3);
        chk(trip_latched, 16'h0000);
        wait_pe(1'h1);
        chk({operator_keypad, fault_free_indicator}, {DISP_NORMAL, 1'h1});
    endtask : s_trip
    task s_aux;
        // Mid-run power-up reset with a trip latched
        @(posedge clk) trip_src <= 16'h0004;
        @(posedge clk) trip_src <= 16'h0000;
        tick(1);
        chk(trip_latched, 16'h0004);
        rst_b <= 1'h0;
        tick(1);
        chk(trip_latched, 16'h0000);
        chk(fault_free_indicator, 16'h0);
        @(posedge clk) rst_b <= 1'h1;
        tick(1);
        chk({fault_free_indicator, power_enable}, 16'h2);
        @(posedge clk) trip_src <= 16'h0001;
        @(posedge clk) trip_src <= 16'h0000;
        aux_supply_ok <= 1'h0;
        tick(2);
        chk(trip_latched, 16'h0001);
        aux_supply_ok <= 1'h1;
        tick(3);
        chk(trip_latched, 16'h0000);
        kp.key_cycle();
        wait_pe(1'h1);
        // Run terminal withdrawn and reasserted clears a transient trip
        @(posedge clk) trip_src <= 16'h0002;
        @(posedge clk) trip_src <= 16'h0000;
        kp.run_cycle();
        tick(2);
        chk({trip_latched, power_enable}, {16'h0000, 1'h1});
    endtask : s_aux
    task s_change;
        req(0, 1'h0);
        req(1, 1'h0);
        req(2, 1'h1);
        run_demand <= 1'h0;
        wait_pe(1'h0);
        req(1, 1'h1);
        out_value <= 8'h5A;
        tick(2);
        chk(out_hold, 8'h5A);
        config_mode <= 1'h1;
        run_demand <= 1'h1;
        tick(2);
        out_value <= 8'hC3;
        tick(3);
        chk({out_hold, power_enable}, {8'h5A, 1'h0});
        req(2, 1'h1);
        req(0, 1'h1);
        config_mode <= 1'h0;
        wait_pe(1'h1);
        chk(out_hold, 8'hC3);
    endtask : s_change
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        tick(1);
        s_power();
        s_trip();
        s_aux();
        s_change();
        summarize();
    end
endmodule : testbench
